/* File: lcd_host_port.sv */
// Host port of a graphic LCD controller: parallel/serial host bus,
// command decode, display RAM with X/Y auto-increment, line output.
// Assumes pins are asynchronous to clock and APB is on clock.
//
// Function
// - interface select high picks parallel bus
// - serial mode is write only, no reads
// - bus style select low means 80-family strobes
// - target select and strobes classify each access
// - serial shifter held reset while deselected
// - serial bits sampled MSB first on rising clock
// - eighth rising edge delivers byte for processing
// - target select marks serial byte register or RAM
// - deselected chip ignores all bus activity
// - write taken on strobe rise or enable fall
// - writes held in bus holder, stored next cycle
// - first RAM read after address set is dummy
// - register read returns preset register, low nibble
// - RAM is 16 X by 64 Y bytes
// - X 10H up and Y 43H up refused
// - auto-increment advances address after RAM write, and after RAM read only while aim is clear
// - six-bit start line register, set by command
// - frame marker loads line counter, line pulse counts
// - latch row on pulse rise, output on fall
// - invert flag swaps lit and unlit dots
// - four-bit read address register, resets to CH
`timescale 1ns/1ns

module lcd_host_port
   import lcd_host_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic [7:0]    paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          interfaceSelect,
   input  wire logic          hostBusStyleSelect,
   input  wire logic          chipSelectN,
   input  wire logic          targetSelect,
   input  wire logic          readStrobeN,
   input  wire logic          writeStrobeN,
   input  wire logic [7:0]    dataIn,
   output logic [7:0]         dataOut,
   output logic               dataOutEnN,
   input  wire logic          serialDataIn,
   input  wire logic          serialClockIn,
   input  wire logic          linePulse,
   input  wire logic          frameMarker,
   output logic [127:0]       segmentData
);

   typedef struct packed {
      logic [17:0] syncA;
      logic [17:0] syncB;
      logic        rdPrev;
      logic        wrPrev;
      logic        holdValid;
      logic [7:0]  holdData;
      logic        holdReg;
      arg_t        argSel;
      logic [3:0]  x;
      logic [7:0]  y;
      logic [5:0]  startLine;
      logic        aim;
      logic        ay;
      logic        ax;
      logic        invert;
      logic [3:0]  readAddr;
      logic [7:0]  readBuf;
      logic        rdRam;
      logic [7:0]  dataOut;
      logic        dataOutEnN;
      logic        hostOn;
      logic [31:0] prdata;
      logic        err;
   } state_t;

   localparam state_t ST_RESET = '{
      syncA:      PIN_RESET,
      syncB:      PIN_RESET,
      rdPrev:     1'b1,
      wrPrev:     1'b1,
      argSel:     ARG_NONE,
      readAddr:   RDADDR_RESET,
      dataOutEnN: 1'b1,
      hostOn:     HOST_ON_RESET,
      default:    '0
   };

   state_t s_reg;
   state_t s_next;

   logic [127:0] ram [RAM_LINES];

   logic [17:0]  pins;
   logic [17:0]  pinS;
   logic         parMode;
   logic         style68;
   logic         csOn;
   logic         tsel;
   logic         strobeA;
   logic         strobeB;
   logic         wrDone;
   logic         rdStart;
   logic         rdEnd;
   logic         yInRam;
   logic [7:0]   ramByte;
   logic         ramWe;
   logic [3:0]   regNibble;
   logic [11:0]  nextXy;
   logic [7:0]   apbData;
   logic         apbHit;

   ser_byte_if serIf ();
   line_if     lineIf ();

   // Advance X/Y for one RAM access as the increment mode selects
   function automatic logic [11:0] incAddr(
      input logic [3:0] xa,
      input logic [7:0] ya,
      input logic       axe,
      input logic       aye
   );
      logic [3:0] xn;
      logic [7:0] yn;
      logic [7:0] yInc;
      xn = xa;
      yn = ya;
      yInc = (ya >= Y_LAST) ? '0 : 8'(ya + 8'h01);
      case ({aye, axe})
         2'b01: begin
            xn = 4'(xa + 4'h1);
         end
         2'b10: begin
            yn = yInc;
         end
         2'b11: begin
            xn = 4'(xa + 4'h1);
            if (xa == X_LAST) begin
               yn = yInc;
            end
         end
         default: begin
            xn = xa;
         end
      endcase
      return {xn, yn};
   endfunction : incAddr

   assign pins = {interfaceSelect, hostBusStyleSelect, chipSelectN,
                  targetSelect, readStrobeN, writeStrobeN, serialDataIn,
                  serialClockIn, linePulse, frameMarker, dataIn};
   assign pinS    = s_reg.syncB;
   assign parMode = pinS[P_IFSEL];
   assign style68 = pinS[P_STYLE];
   assign csOn    = !pinS[P_CSN] && s_reg.hostOn;
   assign tsel    = pinS[P_TSEL];
   // In 68 style the read strobe pin carries read-not-write and the
   // write strobe pin carries the active-high enable
   assign strobeA = pinS[P_RDN];
   assign strobeB = pinS[P_WRN];

   assign wrDone = csOn && parMode &&
                   (style68 ? (fell(s_reg.wrPrev, strobeB) && !strobeA)
                            : rose(s_reg.wrPrev, strobeB));
   assign rdStart = csOn && parMode && s_reg.dataOutEnN &&
                    (style68 ? (rose(s_reg.wrPrev, strobeB) && strobeA)
                             : fell(s_reg.rdPrev, strobeA));
   // Deselect or a mode change also ends a read, so the bus is freed
   assign rdEnd = !s_reg.dataOutEnN &&
                  (!csOn || !parMode ||
                   (style68 ? fell(s_reg.wrPrev, strobeB)
                            : rose(s_reg.rdPrev, strobeA)));

   assign yInRam  = (s_reg.y <= Y_LAST);
   assign ramByte = yInRam ? ram[s_reg.y[5:0]][{s_reg.x, 3'b000} +: 8]
                           : '0;
   assign nextXy  = incAddr(s_reg.x, s_reg.y, s_reg.ax, s_reg.ay);
   assign apbHit  = (paddr == APB_CTRL) || (paddr == APB_STATUS) ||
                    (paddr == APB_MODE);

   always_comb begin
      case (s_reg.readAddr)
         RD_X:       regNibble = s_reg.x;
         RD_YLO:     regNibble = s_reg.y[3:0];
         RD_YHI:     regNibble = s_reg.y[7:4];
         RD_STARTLO: regNibble = s_reg.startLine[3:0];
         RD_STARTHI: regNibble = {2'b00, s_reg.startLine[5:4]};
         RD_ADRCTL:  regNibble = {1'b0, s_reg.aim, s_reg.ay, s_reg.ax};
         RD_INVERT:  regNibble = {3'b000, s_reg.invert};
         default:    regNibble = '0;
      endcase
   end

   always_comb begin
      s_next = s_reg;
      ramWe  = 1'b0;
      s_next.syncA  = pins;
      s_next.syncB  = s_reg.syncA;
      s_next.rdPrev = strobeA;
      s_next.wrPrev = strobeB;

      // Bus holder: a byte taken last cycle is stored now
      if (s_reg.holdValid) begin
         s_next.holdValid = 1'b0;
         if (s_reg.holdReg) begin
            if (s_reg.argSel != ARG_NONE) begin
               s_next.argSel = ARG_NONE;
               case (s_reg.argSel)
                  ARG_X: begin
                     if (s_reg.holdData < X_INHIBIT) begin
                        s_next.x = s_reg.holdData[3:0];
                     end
                  end
                  ARG_Y: begin
                     if (s_reg.holdData < Y_INHIBIT) begin
                        s_next.y = s_reg.holdData;
                     end
                  end
                  ARG_START: begin
                     s_next.startLine = s_reg.holdData[5:0];
                  end
                  default: begin
                     s_next.argSel = ARG_NONE;
                  end
               endcase
            end else begin
               case (s_reg.holdData[7:4])
                  OP_XSET:   s_next.argSel = ARG_X;
                  OP_YSET:   s_next.argSel = ARG_Y;
                  OP_START:  s_next.argSel = ARG_START;
                  OP_ADRCTL: begin
                     s_next.aim = s_reg.holdData[AC_AIM];
                     s_next.ay  = s_reg.holdData[AC_AY];
                     s_next.ax  = s_reg.holdData[AC_AX];
                  end
                  OP_INVERT: s_next.invert = s_reg.holdData[0];
                  OP_RDADDR: begin
                     s_next.readAddr = s_reg.holdData[3:0];
                  end
                  default: begin
                     s_next.argSel = ARG_NONE;
                  end
               endcase
            end
         end else if (yInRam) begin
            ramWe = 1'b1;
            s_next.x = nextXy[11:8];
            s_next.y = nextXy[7:0];
         end
      end

      // Capture into the holder; a new byte wins over the store above
      if (wrDone) begin
         s_next.holdValid = 1'b1;
         s_next.holdData  = pinS[7:0];
         s_next.holdReg   = tsel;
      end else if (serIf.valid && !parMode) begin
         s_next.holdValid = 1'b1;
         s_next.holdData  = serIf.data;
         s_next.holdReg   = serIf.toReg;
      end

      // Register reads give the nibble picked by the read address
      if (rdStart) begin
         s_next.dataOutEnN = 1'b0;
         s_next.rdRam      = !tsel;
         s_next.dataOut    = tsel ? {4'h0, regNibble}
                                  : s_reg.readBuf;
      end else if (rdEnd) begin
         s_next.dataOutEnN = 1'b1;
         if (s_reg.rdRam) begin
            // Prefetch for the next read; this is why a dummy read is due
            s_next.readBuf = ramByte;
            if (!s_reg.aim) begin
               s_next.x = nextXy[11:8];
               s_next.y = nextXy[7:0];
            end
         end
      end

      // APB: data is prepared in setup, answered in the access phase
      if (psel && !penable) begin
         s_next.err = !apbHit;
         case (paddr)
            APB_CTRL:   s_next.prdata = {31'h0, s_reg.hostOn};
            APB_STATUS: s_next.prdata = {parMode, 1'b0,
                                         lineIf.lineCount, 2'b00,
                                         s_reg.startLine, s_reg.y,
                                         4'h0, s_reg.x};
            APB_MODE:   s_next.prdata = {24'h0, s_reg.invert, s_reg.aim,
                                         s_reg.ay, s_reg.ax,
                                         s_reg.readAddr};
            default:    s_next.prdata = '0;
         endcase
      end
      if (psel && penable && pwrite && (paddr == APB_CTRL)) begin
         s_next.hostOn = pwdata[CTRL_HOST_ON_BIT];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= ST_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // RAM has no reset; its content is undefined until written
   always_ff @(posedge clock) begin
      if (ramWe) begin
         ram[s_reg.y[5:0]][{s_reg.x, 3'b000} +: 8] <= s_reg.holdData;
      end
   end

   lcd_serial_rx serialRx (
      .clock   (clock),
      .nrst    (nrst),
      .active  (csOn && !parMode),
      .sclk    (pinS[P_SCLK]),
      .sdata   (pinS[P_SDA]),
      .toReg   (tsel),
      .byteOut (serIf.src)
   );

   assign lineIf.startLine = s_reg.startLine;
   assign lineIf.invert    = s_reg.invert;
   assign lineIf.rowData   = ram[lineIf.lineCount];

   lcd_line_drive lineDrive (
      .clock       (clock),
      .nrst        (nrst),
      .linePulse   (pinS[P_LINE]),
      .frameMarker (pinS[P_FRAME]),
      .lineBus     (lineIf.disp),
      .segmentData (segmentData)
   );

   assign apbData    = s_reg.prdata[7:0];
   assign prdata     = {s_reg.prdata[31:8], apbData};
   assign pready     = psel && penable;
   assign pslverr    = psel && penable && s_reg.err;
   assign dataOut    = s_reg.dataOut;
   assign dataOutEnN = s_reg.dataOutEnN;

endmodule : lcd_host_port

/* File: lcd_host_pkg.sv */
// Shared constants and helpers for the LCD host port.
// Assumes one 100 MHz clock domain; all pins arrive unsynchronised.
package lcd_host_pkg;

   // APB register byte offsets
   localparam logic [7:0] APB_CTRL   = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_MODE   = 8'h08;
   localparam int         CTRL_HOST_ON_BIT = 0;
   localparam logic       HOST_ON_RESET    = 1'b1;

   // Command opcodes (upper nibble of a register write)
   localparam logic [3:0] OP_ADRCTL = 4'h5;
   localparam logic [3:0] OP_INVERT = 4'h6;
   localparam logic [3:0] OP_XSET   = 4'h8;
   localparam logic [3:0] OP_YSET   = 4'h9;
   localparam logic [3:0] OP_START  = 4'ha;
   localparam logic [3:0] OP_RDADDR = 4'hc;
   localparam int         AC_AIM = 2;
   localparam int         AC_AY  = 1;
   localparam int         AC_AX  = 0;

   // Internal register read addresses
   localparam logic [3:0] RD_X       = 4'h0;
   localparam logic [3:0] RD_YLO     = 4'h1;
   localparam logic [3:0] RD_YHI     = 4'h2;
   localparam logic [3:0] RD_STARTLO = 4'h3;
   localparam logic [3:0] RD_STARTHI = 4'h4;
   localparam logic [3:0] RD_ADRCTL  = 4'h5;
   localparam logic [3:0] RD_INVERT  = 4'h6;
   localparam logic [3:0] RDADDR_RESET = 4'hc;

   // Display RAM address space
   localparam logic [3:0] X_LAST     = 4'hf;
   localparam logic [7:0] X_INHIBIT  = 8'h10;
   localparam logic [7:0] Y_LAST     = 8'h3f;
   localparam logic [7:0] Y_INHIBIT  = 8'h43;
   localparam int         RAM_LINES  = 64;
   localparam int         RAM_BITS   = 128;
   localparam logic [2:0] SER_LAST   = 3'h7;

   // Pin vector layout
   localparam int P_IFSEL = 17;
   localparam int P_STYLE = 16;
   localparam int P_CSN   = 15;
   localparam int P_TSEL  = 14;
   localparam int P_RDN   = 13;
   localparam int P_WRN   = 12;
   localparam int P_SDA   = 11;
   localparam int P_SCLK  = 10;
   localparam int P_LINE  = 9;
   localparam int P_FRAME = 8;
   localparam logic [17:0] PIN_RESET = 18'h0b000;

   typedef enum logic [1:0] {
      ARG_NONE  = 2'b00,
      ARG_X     = 2'b01,
      ARG_Y     = 2'b10,
      ARG_START = 2'b11
   } arg_t;

   function automatic logic rose(input logic prev, input logic cur);
      return !prev && cur;
   endfunction : rose

   function automatic logic fell(input logic prev, input logic cur);
      return prev && !cur;
   endfunction : fell

endpackage : lcd_host_pkg

/* File: lcd_host_if.sv */
// Interfaces between the host port top and its two sub-blocks.
// Assumes all members are driven in the single clock domain.
`timescale 1ns/1ns

interface ser_byte_if;
   logic       valid;
   logic [7:0] data;
   logic       toReg;
   modport src (output valid, data, toReg);
   modport dst (input  valid, data, toReg);
endinterface : ser_byte_if

interface line_if;
   logic [5:0]   startLine;
   logic         invert;
   logic [127:0] rowData;
   logic [5:0]   lineCount;
   modport disp (input startLine, invert, rowData, output lineCount);
   modport ctl  (output startLine, invert, rowData, input lineCount);
endinterface : line_if

/* File: lcd_serial_rx.sv */
// Serial write-only receiver: assembles bytes from the serial clock.
// Assumes clock and data pins are already synchronised by the caller.
`timescale 1ns/1ns

module lcd_serial_rx
   import lcd_host_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   nrst,
   input  wire logic   active,
   input  wire logic   sclk,
   input  wire logic   sdata,
   input  wire logic   toReg,
   ser_byte_if.src     byteOut
);

   typedef struct packed {
      logic       sclkPrev;
      logic [6:0] shift;
      logic [2:0] count;
      logic       valid;
      logic [7:0] data;
      logic       toReg;
   } ser_state_t;

   ser_state_t s_reg;
   ser_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.valid = 1'b0;
      s_next.sclkPrev = sclk;
      if (!active) begin
         s_next.shift = '0;
         s_next.count = '0;
      end else if (rose(s_reg.sclkPrev, sclk)) begin
         if (s_reg.count == SER_LAST) begin
            s_next.data  = {s_reg.shift, sdata};
            s_next.toReg = toReg;
            s_next.valid = 1'b1;
            s_next.count = '0;
         end else begin
            s_next.shift = {s_reg.shift[5:0], sdata};
            s_next.count = 3'(s_reg.count + 3'h1);
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign byteOut.valid = s_reg.valid;
   assign byteOut.data  = s_reg.data;
   assign byteOut.toReg = s_reg.toReg;

endmodule : lcd_serial_rx

/* File: lcd_line_drive.sv */
// Display line counter and 128-bit segment data latch.
// Assumes line and frame pulses are synchronised by the caller.
`timescale 1ns/1ns

module lcd_line_drive
   import lcd_host_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          linePulse,
   input  wire logic          frameMarker,
   line_if.disp               lineBus,
   output logic [127:0]       segmentData
);

   typedef struct packed {
      logic         linePrev;
      logic [127:0] latched;
      logic [127:0] seg;
      logic [5:0]   lineCount;
   } line_state_t;

   line_state_t s_reg;
   line_state_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.linePrev = linePulse;
      if (rose(s_reg.linePrev, linePulse)) begin
         s_next.latched = lineBus.rowData;
      end
      if (fell(s_reg.linePrev, linePulse)) begin
         // A set RAM bit lights its dot unless the display is inverted
         s_next.seg = s_reg.latched ^ {RAM_BITS{lineBus.invert}};
      end
      if (frameMarker) begin
         s_next.lineCount = lineBus.startLine;
      end else if (fell(s_reg.linePrev, linePulse)) begin
         s_next.lineCount = 6'(s_reg.lineCount + 6'h01);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lineBus.lineCount = s_reg.lineCount;
   assign segmentData       = s_reg.seg;

endmodule : lcd_line_drive

/* File: lcd_host_port_assertions.sv */
// Concurrent checks on the LCD host port top-level pins.
// Assumes the bench never clears the host-on bit.
`timescale 1ns/1ns

module lcd_host_port_checker (
   input wire logic         clock,
   input wire logic         nrst,
   input wire logic [7:0]   paddr,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire logic         interfaceSelect,
   input wire logic         hostBusStyleSelect,
   input wire logic         chipSelectN,
   input wire logic         readStrobeN,
   input wire logic         writeStrobeN,
   input wire logic         dataOutEnN,
   input wire logic         linePulse,
   input wire logic [127:0] segmentData
);
   logic       lpPrev;
   logic [3:0] fallAge;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Cycles since the line pulse pin fell; saturates so it never wraps
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lpPrev  <= 1'b0;
         fallAge <= 4'hf;
      end else begin
         lpPrev <= linePulse;
         if (lpPrev && !linePulse) fallAge <= 4'h0;
         else if (fallAge != 4'hf) fallAge <= fallAge + 4'h1;
      end
   end
   sequence rdHeld;
      (!chipSelectN && interfaceSelect && !hostBusStyleSelect &&
       !readStrobeN && writeStrobeN) [*6];
   endsequence
   sequence rdEnd;
      $rose(readStrobeN) && !hostBusStyleSelect;
   endsequence
   sequence setupAt(logic mapped);
      psel && !penable && (paddr inside {8'h00, 8'h04, 8'h08}) == mapped;
   endsequence
   a_ready_access: assert property (pready == (psel && penable))
      else $error("pready wrong");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("stray pslverr");
   a_err_unmapped: assert property (setupAt(1'b0) ##1 penable |-> pslverr)
      else $error("no pslverr");
   a_ok_mapped: assert property (setupAt(1'b1) ##1 penable |-> !pslverr)
      else $error("bad pslverr");
   a_rdata_idle: assert property (!psel ##1 !psel |-> $stable(prdata))
      else $error("prdata moved");
   a_read_drives: assert property (rdHeld |-> !dataOutEnN)
      else $error("read not driven");
   a_read_release: assert property (rdEnd |-> ##[1:6] dataOutEnN)
      else $error("bus not released");
   a_serial_quiet: assert property ((!interfaceSelect) [*6] |-> dataOutEnN)
      else $error("serial drive");
   a_desel_quiet: assert property (chipSelectN [*8] |-> dataOutEnN)
      else $error("deselect drive");
   a_seg_on_fall: assert property ($changed(segmentData) |-> fallAge <= 4'h6)
      else $error("segment moved");
endmodule : lcd_host_port_checker

bind lcd_host_port lcd_host_port_checker lcd_host_port_checker_inst (.*);

/* File: host_mpu_model.sv */
// Behavioural 8-bit host driving the port's parallel and serial pins.
// Assumes its tasks are called from one bench process, after a clock edge.
`timescale 1ns/1ns

module host_mpu_model (
   input  wire logic       clock,
   input  wire logic [7:0] dataOut,
   input  wire logic       dataOutEnN,
   output logic            interfaceSelect = 1'b1,
   output logic            hostBusStyleSelect = 1'b0,
   output logic            chipSelectN = 1'b1,
   output logic            targetSelect = 1'b0,
   output logic            readStrobeN = 1'b1,
   output logic            writeStrobeN = 1'b1,
   output logic [7:0]      dataIn = 8'h00,
   output logic            serialDataIn = 1'b0,
   output logic            serialClockIn = 1'b0
);
   task automatic gap(input int n);
      repeat (n) @(posedge clock);
   endtask : gap
   // Idle enable strobe is low in the 68 style, write strobe high in 80
   task automatic style(input logic p, input logic s);
      interfaceSelect <= p;
      hostBusStyleSelect <= s;
      writeStrobeN <= !s;
      gap(6);
   endtask : style
   // Select and data settle five cycles ahead of the strobe edge
   task automatic access(input logic csN, input logic rd, input logic tsel,
                         input logic [7:0] d, output logic [7:0] q);
      chipSelectN <= csN;
      targetSelect <= tsel;
      dataIn <= d;
      if (hostBusStyleSelect) readStrobeN <= rd;
      gap(5);
      if (hostBusStyleSelect) writeStrobeN <= 1'b1;
      else if (rd) readStrobeN <= 1'b0;
      else writeStrobeN <= 1'b0;
      gap(6);
      q = dataOutEnN ? 8'hxx : dataOut;
      writeStrobeN <= !hostBusStyleSelect;
      if (!hostBusStyleSelect) readStrobeN <= 1'b1;
      gap(5);
      readStrobeN <= 1'b1;
      chipSelectN <= 1'b1;
      dataIn <= ~d; // Released bus must not keep the old byte
      gap(2);
   endtask : access
   task automatic ser(input logic tsel, input logic [7:0] d, input int n);
      chipSelectN <= 1'b0;
      targetSelect <= tsel;
      gap(8);
      for (int i = 7; i > 7 - n; i--) begin
         serialDataIn <= d[i];
         gap(8);
         serialClockIn <= 1'b1;
         gap(8);
         serialClockIn <= 1'b0;
      end
      gap(8);
      chipSelectN <= 1'b1;
      serialDataIn <= ~serialDataIn;
      gap(8);
   endtask : ser
endmodule : host_mpu_model

/* File: lcd_host_port_test.sv */
// Self-checking bench: APB master, host model and line timing stimulus.
// Assumes the port's command opcodes and APB map from its package.
`timescale 1ns/1ns

module lcd_host_port_test
   import lcd_host_pkg::*;
;
   logic         clock = 1'b0;
   logic         nrst = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0]  pwdata = 32'h0;
   logic         linePulse = 1'b0, frameMarker = 1'b0;
   logic [31:0]  prdata, q;
   logic         pready, pslverr, e, dataOutEnN, serialDataIn, serialClockIn;
   logic         interfaceSelect, hostBusStyleSelect, chipSelectN;
   logic         targetSelect, readStrobeN, writeStrobeN;
   logic [7:0]   dataIn, dataOut, b;
   logic [127:0] segmentData;
   int           num_errors = 0;
   int           tests_run = 0;

   lcd_host_port lcd_host_port_inst (.*);
   host_mpu_model host_mpu_model_inst (.*);

   always #5 clock = ~clock;

   task automatic end_sim();
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         num_errors++;
         end_sim();
      end
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task automatic hw(input logic tsel, input logic [7:0] d);
      host_mpu_model_inst.access(1'b0, 1'b0, tsel, d, b);
   endtask : hw
   task automatic hchk(input logic tsel, input logic [31:0] exp);
      host_mpu_model_inst.access(1'b0, 1'b1, tsel, 8'h00, b);
      chk({24'h0, b}, exp);
   endtask : hchk
   task automatic cmd2(input logic [3:0] op, input logic [7:0] arg);
      hw(1'b1, {op, 4'h0});
      hw(1'b1, arg);
   endtask : cmd2
   // Frame marker spans the whole pulse so the load wins over counting
   task automatic pulse(input logic frame);
      frameMarker <= frame;
      repeat (6) @(posedge clock);
      linePulse <= 1'b1;
      repeat (6) @(posedge clock);
      linePulse <= 1'b0;
      repeat (8) @(posedge clock);
      frameMarker <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : pulse
   task automatic stat(input logic p, input logic [5:0] lc,
      input logic [5:0] s, input logic [7:0] y, input logic [3:0] x);
      rd(APB_STATUS, {p, 1'b0, lc, 2'b00, s, y, 4'h0, x});
   endtask : stat

   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      rd(APB_MODE, {28'h0, RDADDR_RESET});
      stat(1'b1, 6'h0, 6'h0, 8'h00, 4'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, APB_CTRL, 32'h1);
      rd(APB_CTRL, 32'h1);
      $display("test apb done");
      cmd2(OP_XSET, 8'h03);
      cmd2(OP_YSET, 8'h05);
      stat(1'b1, 6'h0, 6'h0, 8'h05, 4'h3);
      cmd2(OP_XSET, X_INHIBIT);
      cmd2(OP_YSET, Y_INHIBIT);
      stat(1'b1, 6'h0, 6'h0, 8'h05, 4'h3);
      $display("test address done");
      hw(1'b1, {OP_ADRCTL, 4'h1});
      rd(APB_MODE, 32'h1c);
      cmd2(OP_XSET, 8'h00);
      hw(1'b0, 8'ha5);
      hw(1'b0, 8'h3c);
      stat(1'b1, 6'h0, 6'h0, 8'h05, 4'h2);
      cmd2(OP_XSET, 8'h00);
      host_mpu_model_inst.access(1'b0, 1'b1, 1'b0, 8'h00, b);
      hchk(1'b0, 32'ha5);
      hchk(1'b0, 32'h3c);
      hw(1'b1, {OP_RDADDR, RD_X});
      hchk(1'b1, 32'h03);
      hw(1'b1, {OP_RDADDR, RD_ADRCTL});
      hchk(1'b1, 32'h01);
      $display("test ram done");
      host_mpu_model_inst.style(1'b1, 1'b1);
      cmd2(OP_XSET, 8'h0a);
      host_mpu_model_inst.access(1'b1, 1'b0, 1'b1, {OP_XSET, 4'h0}, b);
      host_mpu_model_inst.access(1'b1, 1'b0, 1'b1, 8'h07, b);
      hw(1'b1, {OP_RDADDR, RD_X});
      hchk(1'b1, 32'h0a);
      host_mpu_model_inst.style(1'b1, 1'b0);
      $display("test style done");
      cmd2(OP_XSET, 8'h00);
      hw(1'b0, 8'h96);
      cmd2(OP_START, 8'h05);
      pulse(1'b1);
      chk({24'h0, segmentData[7:0]}, 32'h96);
      stat(1'b1, 6'h05, 6'h05, 8'h05, 4'h1);
      pulse(1'b0);
      stat(1'b1, 6'h06, 6'h05, 8'h05, 4'h1);
      hw(1'b1, {OP_INVERT, 4'h1});
      pulse(1'b1);
      chk({24'h0, segmentData[7:0]}, 32'h69);
      $display("test line done");
      host_mpu_model_inst.style(1'b0, 1'b0);
      host_mpu_model_inst.ser(1'b1, {OP_XSET, 4'h0}, 3);
      host_mpu_model_inst.ser(1'b1, {OP_XSET, 4'h0}, 8);
      host_mpu_model_inst.ser(1'b1, 8'h07, 8);
      host_mpu_model_inst.ser(1'b0, 8'hff, 8);
      stat(1'b0, 6'h05, 6'h05, 8'h05, 4'h8);
      $display("test serial done");
      end_sim();
   end
endmodule : lcd_host_port_test
